// File: core/light_prox_cfg.svh
// Constants of the light and proximity sensor register block.
`ifndef LIGHT_PROX_CFG_SVH
`define LIGHT_PROX_CFG_SVH

// ==========================================================
// Register offsets
`define OFS_WAIT_CFG 8'h0d
`define OFS_PULSE_CNT 8'h0e
`define OFS_ANALOG_CTRL 8'h0f
`define OFS_PART_ID 8'h12
`define OFS_STATUS 8'h13
`define OFS_CLEAR_LO 8'h14
`define OFS_CLEAR_HI 8'h15
`define OFS_IR_LO 8'h16
`define OFS_IR_HI 8'h17
`define OFS_PROX_LO 8'h18
`define OFS_PROX_HI 8'h19

// ==========================================================
// Field positions, reset values and time-unit scaling
`define WAIT_EXT_BIT 1
`define RESET_BYTE 8'h00
`define WAIT_EXT_FACTOR 12'h00c
`define STEP_BASE 12'h100

// ==========================================================
// Timing
`define SYS_CLK_HZ 10000000
`define PULSE_RATE_HZ 62500
`define PULSE_CYCLES (`SYS_CLK_HZ / `PULSE_RATE_HZ)

`endif

// File: core/light_prox_pkg.sv
// Types shared by the light and proximity register block.
package light_prox_pkg;

  typedef enum logic [1:0]
  {
    SEQ_IDLE = 2'b00,
    SEQ_INTEG = 2'b01,
    SEQ_PROX = 2'b11,
    SEQ_WAIT = 2'b10
  } seq_state_t;

  typedef struct packed
  {
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed
  {
    logic [1:0] led_sink_strength;
    logic [1:0] prox_photodiode_select;
    logic [1:0] unused;
    logic [1:0] light_gain_select;
  } analog_ctrl_t;

endpackage : light_prox_pkg

// File: core/link_port.sv
// Link-clock side of the register access port with handshake crossing.
`timescale 1ns/1ps
`default_nettype none
`include "light_prox_cfg.svh"
module link_port
(
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // Host side, on the link clock
  input wire logic host_req,
  input wire light_prox_pkg::reg_req_t host_cmd,
  output logic host_busy,
  output logic host_done,
  output logic [7:0] host_rdata,
  // Core side
  output light_prox_pkg::reg_req_t req_hold,
  output logic req_tgl,
  input wire logic ack_tgl,
  input wire logic [7:0] core_rdata
);

  light_prox_pkg::reg_req_t hold_reg, hold_next;
  logic tgl_reg, tgl_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [7:0] rdata_reg, rdata_next;
  logic ack_s1_reg, ack_s2_reg, ack_seen_reg, ack_seen_next;

  // The command stays frozen while busy, so the core may sample it safely.
  always_comb
  begin
    hold_next = hold_reg;
    tgl_next = tgl_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    ack_seen_next = ack_seen_reg;
    if (!busy_reg && host_req)
    begin
      hold_next = host_cmd;
      tgl_next = ~tgl_reg;
      busy_next = 1'b1;
    end
    else if (busy_reg && (ack_s2_reg != ack_seen_reg))
    begin
      ack_seen_next = ack_s2_reg;
      busy_next = 1'b0;
      done_next = 1'b1;
      rdata_next = core_rdata;
    end
  end

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
    begin
      hold_reg <= '0;
      tgl_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= `RESET_BYTE;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_seen_reg <= 1'b0;
    end
    else
    begin
      hold_reg <= hold_next;
      tgl_reg <= tgl_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      ack_s1_reg <= ack_tgl;
      ack_s2_reg <= ack_s1_reg;
      ack_seen_reg <= ack_seen_next;
    end
  end

  assign req_hold = hold_reg;
  assign req_tgl = tgl_reg;
  assign host_busy = busy_reg;
  assign host_done = done_reg;
  assign host_rdata = rdata_reg;

  busy_hold_a: assert property (@(posedge link_clk) disable iff (rst)
    busy_reg && !done_next |=> $stable(hold_reg))
    else $error("command changed while busy");

endmodule : link_port
`default_nettype wire

// File: core/light_prox_regs.sv
// Register file, result shadows and measurement sequencer of the sensor.
`timescale 1ns/1ps
`default_nettype none
`include "light_prox_cfg.svh"
module light_prox_regs
#(
  parameter int STEP_CYCLES = 100
)
(
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host link, on its own clock
  input wire logic link_clk,
  input wire logic host_req,
  input wire light_prox_pkg::reg_req_t host_cmd,
  output logic host_busy,
  output logic host_done,
  output logic [7:0] host_rdata,
  // Enables and timing from the rest of the device
  input wire logic light_enable,
  input wire logic prox_enable,
  input wire logic wait_enable,
  input wire logic [7:0] integration_time_setting,
  input wire logic [7:0] wait_time_setting,
  input wire logic [7:0] status_in,
  // Conversion results
  input wire logic light_result_valid,
  input wire logic [15:0] clear_result_in,
  input wire logic [15:0] ir_result_in,
  input wire logic prox_result_valid,
  input wire logic [15:0] prox_result_in,
  // Analog front end
  output logic led_pulse,
  output logic [9:0] led_sink_tenth_ma,
  output logic photodiode_clear_sel,
  output logic photodiode_ir_sel,
  output logic [6:0] light_gain_factor,
  output logic light_cycle_done,
  output logic prox_cycle_done
);

  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);
  localparam logic [15:0] PULSE_LAST = 16'(`PULSE_CYCLES - 1);
  localparam logic [15:0] PULSE_HALF = 16'(`PULSE_CYCLES / 2);
  localparam logic [7:0] PART_ID = 8'h5a; // Arbitrary identity value.

  // ==========================================================
  // Link crossing
  light_prox_pkg::reg_req_t req_hold;
  logic req_tgl;
  logic req_s1_reg, req_s2_reg, req_seen_reg;
  logic ack_reg, ack_next;
  logic [7:0] rdata_reg, rdata_next;
  logic acc;

  link_port u_link
  (
    .link_clk(link_clk),
    .rst(rst),
    .host_req(host_req),
    .host_cmd(host_cmd),
    .host_busy(host_busy),
    .host_done(host_done),
    .host_rdata(host_rdata),
    .req_hold(req_hold),
    .req_tgl(req_tgl),
    .ack_tgl(ack_reg),
    .core_rdata(rdata_reg)
  );

  assign acc = req_s2_reg != req_seen_reg;

  // ==========================================================
  // Registers
  logic [7:0] wcfg_reg, wcfg_next;
  logic [7:0] pulse_reg, pulse_next;
  light_prox_pkg::analog_ctrl_t ctrl_reg, ctrl_next;
  logic [15:0] clear_reg, clear_next, ir_reg, ir_next, prox_reg, prox_next;
  logic [7:0] clear_sh_reg, clear_sh_next, ir_sh_reg, ir_sh_next;
  logic [7:0] prox_sh_reg, prox_sh_next;
  logic rd, wr;

  assign rd = acc && !req_hold.write;
  assign wr = acc && req_hold.write;

  always_comb
  begin
    wcfg_next = wcfg_reg;
    pulse_next = pulse_reg;
    ctrl_next = ctrl_reg;
    clear_next = light_result_valid ? clear_result_in : clear_reg;
    ir_next = light_result_valid ? ir_result_in : ir_reg;
    prox_next = prox_result_valid ? prox_result_in : prox_reg;
    clear_sh_next = clear_sh_reg;
    ir_sh_next = ir_sh_reg;
    prox_sh_next = prox_sh_reg;
    rdata_next = rdata_reg;
    ack_next = acc ? ~ack_reg : ack_reg;
    // Identity, status and result offsets have no write path.
    if (wr)
    begin
      unique case (req_hold.addr)
        `OFS_WAIT_CFG: wcfg_next = req_hold.wdata;
        `OFS_PULSE_CNT: pulse_next = req_hold.wdata;
        `OFS_ANALOG_CTRL: ctrl_next = req_hold.wdata;
        default: ;
      endcase
    end
    if (rd)
    begin
      unique case (req_hold.addr)
        `OFS_WAIT_CFG: rdata_next = wcfg_reg;
        `OFS_PULSE_CNT: rdata_next = pulse_reg;
        `OFS_ANALOG_CTRL: rdata_next = ctrl_reg;
        `OFS_PART_ID: rdata_next = PART_ID;
        `OFS_STATUS: rdata_next = status_in;
        `OFS_CLEAR_LO:
        begin
          rdata_next = clear_reg[7:0];
          clear_sh_next = clear_reg[15:8];
        end
        `OFS_CLEAR_HI: rdata_next = clear_sh_reg;
        `OFS_IR_LO:
        begin
          rdata_next = ir_reg[7:0];
          ir_sh_next = ir_reg[15:8];
        end
        `OFS_IR_HI: rdata_next = ir_sh_reg;
        `OFS_PROX_LO:
        begin
          rdata_next = prox_reg[7:0];
          prox_sh_next = prox_reg[15:8];
        end
        `OFS_PROX_HI: rdata_next = prox_sh_reg;
        default: rdata_next = `RESET_BYTE;
      endcase
    end
  end

  // ==========================================================
  // Sequencer
  light_prox_pkg::seq_state_t st_reg, st_next;
  logic [15:0] sub_reg, sub_next;
  logic [11:0] unit_reg, unit_next;
  logic [7:0] pcnt_reg, pcnt_next;
  logic run, step_end, pulse_end;
  logic [11:0] integ_units, wait_units;
  logic led_next, ldone_next, pdone_next;

  assign run = light_enable || prox_enable;
  assign step_end = sub_reg == STEP_LAST;
  assign pulse_end = sub_reg == PULSE_LAST;
  assign integ_units = 12'(`STEP_BASE - {4'h0, integration_time_setting});
  // Base wait units, scaled twelvefold by the extend bit.
  assign wait_units = wcfg_reg[`WAIT_EXT_BIT]
    ? 12'((`STEP_BASE - {4'h0, wait_time_setting}) * `WAIT_EXT_FACTOR)
    : 12'(`STEP_BASE - {4'h0, wait_time_setting});

  always_comb
  begin
    st_next = st_reg;
    sub_next = sub_reg + 16'h0001;
    unit_next = unit_reg;
    pcnt_next = pcnt_reg;
    ldone_next = 1'b0;
    pdone_next = 1'b0;
    unique case (st_reg)
      light_prox_pkg::SEQ_IDLE:
      begin
        sub_next = 16'h0000;
        if (run)
        begin
          st_next = light_prox_pkg::SEQ_INTEG;
          unit_next = integ_units;
        end
      end
      light_prox_pkg::SEQ_INTEG:
      begin
        if (step_end)
        begin
          sub_next = 16'h0000;
          unit_next = unit_reg - 12'h001;
          if (unit_reg == 12'h001)
          begin
            ldone_next = 1'b1;
            if (prox_enable)
            begin
              st_next = light_prox_pkg::SEQ_PROX;
              pcnt_next = pulse_reg;
            end
            else if (wait_enable)
            begin
              st_next = light_prox_pkg::SEQ_WAIT;
              unit_next = wait_units;
            end
            else if (!run)
              st_next = light_prox_pkg::SEQ_IDLE;
            else
              unit_next = integ_units;
          end
        end
      end
      light_prox_pkg::SEQ_PROX:
      begin
        if (pulse_end)
        begin
          sub_next = 16'h0000;
          pcnt_next = pcnt_reg - 8'h01;
          if (pcnt_reg <= 8'h01)
          begin
            pcnt_next = 8'h00;
            pdone_next = 1'b1;
            if (wait_enable)
            begin
              st_next = light_prox_pkg::SEQ_WAIT;
              unit_next = wait_units;
            end
            else
            begin
              st_next = light_prox_pkg::SEQ_INTEG;
              unit_next = integ_units;
            end
          end
        end
      end
      light_prox_pkg::SEQ_WAIT:
      begin
        if (step_end)
        begin
          sub_next = 16'h0000;
          unit_next = unit_reg - 12'h001;
          if (unit_reg == 12'h001)
          begin
            st_next = run ? light_prox_pkg::SEQ_INTEG : light_prox_pkg::SEQ_IDLE;
            unit_next = integ_units;
          end
        end
      end
    endcase
    // One pulse per 16 us slot, high for the first half of the slot.
    led_next = st_next == light_prox_pkg::SEQ_PROX && pcnt_next != 8'h00
      && sub_next < PULSE_HALF;
  end

  // ==========================================================
  // Analog decode
  logic [9:0] sink_next;
  logic [6:0] gain_next;
  logic csel_next, isel_next;

  always_comb
  begin
    unique case (ctrl_reg.led_sink_strength)
      2'b00: sink_next = 10'h3e8;
      2'b01: sink_next = 10'h1f4;
      2'b10: sink_next = 10'h0fa;
      2'b11: sink_next = 10'h07d;
    endcase
    // Code 00 is reserved and drives no diode.
    csel_next = ctrl_reg.prox_photodiode_select[0];
    isel_next = ctrl_reg.prox_photodiode_select[1];
    unique case (ctrl_reg.light_gain_select)
      2'b00: gain_next = 7'h01;
      2'b01: gain_next = 7'h08;
      2'b10: gain_next = 7'h10;
      2'b11: gain_next = 7'h78;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_seen_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= `RESET_BYTE;
      wcfg_reg <= `RESET_BYTE;
      pulse_reg <= `RESET_BYTE;
      ctrl_reg <= `RESET_BYTE;
      clear_reg <= 16'h0000;
      ir_reg <= 16'h0000;
      prox_reg <= 16'h0000;
      clear_sh_reg <= `RESET_BYTE;
      ir_sh_reg <= `RESET_BYTE;
      prox_sh_reg <= `RESET_BYTE;
      st_reg <= light_prox_pkg::SEQ_IDLE;
      sub_reg <= 16'h0000;
      unit_reg <= 12'h000;
      pcnt_reg <= 8'h00;
      led_pulse <= 1'b0;
      light_cycle_done <= 1'b0;
      prox_cycle_done <= 1'b0;
      led_sink_tenth_ma <= 10'h3e8;
      photodiode_clear_sel <= 1'b0;
      photodiode_ir_sel <= 1'b0;
      light_gain_factor <= 7'h01;
    end
    else
    begin
      req_s1_reg <= req_tgl;
      req_s2_reg <= req_s1_reg;
      req_seen_reg <= req_s2_reg;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      wcfg_reg <= wcfg_next;
      pulse_reg <= pulse_next;
      ctrl_reg <= ctrl_next;
      clear_reg <= clear_next;
      ir_reg <= ir_next;
      prox_reg <= prox_next;
      clear_sh_reg <= clear_sh_next;
      ir_sh_reg <= ir_sh_next;
      prox_sh_reg <= prox_sh_next;
      st_reg <= st_next;
      sub_reg <= sub_next;
      unit_reg <= unit_next;
      pcnt_reg <= pcnt_next;
      led_pulse <= led_next;
      light_cycle_done <= ldone_next;
      prox_cycle_done <= pdone_next;
      led_sink_tenth_ma <= sink_next;
      photodiode_clear_sel <= csel_next;
      photodiode_ir_sel <= isel_next;
      light_gain_factor <= gain_next;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence read_at(logic [7:0] a);
    rd && req_hold.addr == a;
  endsequence

  clear_shadow_a: assert property (read_at(`OFS_CLEAR_LO) ##1 1'b1
    |-> clear_sh_reg == $past(clear_reg[15:8]))
    else $error("clear shadow not captured");
  ir_shadow_a: assert property (read_at(`OFS_IR_LO)
    |=> ir_sh_reg == $past(ir_reg[15:8]) && rdata_reg == $past(ir_reg[7:0]))
    else $error("ir shadow not captured");
  high_coherent_a: assert property (read_at(`OFS_CLEAR_LO) ##[1:300]
    read_at(`OFS_CLEAR_HI) |=> rdata_reg == $past(clear_sh_reg))
    else $error("clear high byte not from shadow");
  prox_shadow_a: assert property (read_at(`OFS_PROX_LO) ##[1:300]
    read_at(`OFS_PROX_HI) |=> rdata_reg == $past(prox_sh_reg))
    else $error("prox high byte incoherent");
  id_fixed_a: assert property (read_at(`OFS_PART_ID) |=> rdata_reg == PART_ID)
    else $error("identity value wrong");
  status_read_a: assert property (read_at(`OFS_STATUS) |=> rdata_reg == $past(status_in))
    else $error("status value wrong");
  wait_scale_a: assert property ($changed(st_reg) && st_reg == light_prox_pkg::SEQ_WAIT
    && wcfg_reg[`WAIT_EXT_BIT] |-> unit_reg == 12'(
    (`STEP_BASE - {4'h0, $past(wait_time_setting)}) * `WAIT_EXT_FACTOR))
    else $error("wait not extended twelvefold");
  prox_follows_a: assert property (st_reg == light_prox_pkg::SEQ_INTEG && step_end
    && unit_reg == 12'h001 && prox_enable |=> st_reg == light_prox_pkg::SEQ_PROX
    && pcnt_reg == $past(pulse_reg) && light_cycle_done)
    else $error("proximity cycle not started");
  sink_decode_a: assert property (ctrl_reg.led_sink_strength == 2'b11
    |=> led_sink_tenth_ma == 10'h07d)
    else $error("led sink decode wrong");
  gain_decode_a: assert property (ctrl_reg.light_gain_select == 2'b11
    |=> light_gain_factor == 7'h78)
    else $error("gain decode wrong");

endmodule : light_prox_regs
`default_nettype wire

// File: sim/host_link_model.sv
// Host processor model that issues byte accesses on the register link.
`timescale 1ns/1ps
`default_nettype none
module host_link_model
(
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // Access port toward the device
  output logic host_req,
  output light_prox_pkg::reg_req_t host_cmd,
  input wire logic host_busy,
  input wire logic host_done,
  input wire logic [7:0] host_rdata
);
  // Accesses that never completed; the bench counts them as mismatches.
  int timeouts = 0;

  initial
  begin
    host_req = 1'h0;
    host_cmd = '0;
  end

  // ==========================================================
  // Single access
  // The command is inverted once released, so a device that samples late sees junk.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    int n;
    rdata = 8'h00;
    @(negedge link_clk);
    while (host_busy !== 1'h0 || rst !== 1'h0)
    begin
      @(negedge link_clk);
    end
    host_cmd = '{write: wr, addr: addr, wdata: wdata};
    host_req = 1'h1;
    @(negedge link_clk);
    host_req = 1'h0;
    host_cmd = ~host_cmd;
    n = 0;
    while (host_done !== 1'h1 && n < 40)
    begin
      @(negedge link_clk);
      n++;
    end
    if (n >= 40) timeouts++;
    rdata = host_rdata;
  endtask : access

  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    logic [7:0] junk;
    d = data;
    if (addr == 8'h0d) d = d & 8'h02;
    if (addr == 8'h0f) d = d & 8'hf3;
    access(1'h1, addr, d, junk);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    access(1'h0, addr, 8'h00, data);
  endtask : read_reg

  // Low byte first, then high byte straight after, as two separate accesses.
  task automatic read16(input logic [7:0] addr, output logic [15:0] data);
    read_reg(addr, data[7:0]);
    read_reg(addr + 8'h01, data[15:8]);
  endtask : read16
endmodule : host_link_model
`default_nettype wire

// File: sim/light_prox_regs_tb.sv
// Self-checking bench for the sensor register block.
`timescale 1ns/1ps
`default_nettype none
module light_prox_regs_tb;
  localparam int STEP = 4;
  logic sys_clk = 1'h0;
  logic link_clk = 1'h0;
  logic rst = 1'h1;
  logic host_req;
  logic host_busy;
  logic host_done;
  light_prox_pkg::reg_req_t host_cmd;
  logic [7:0] host_rdata;
  logic [7:0] rd;
  logic [7:0] id0;
  logic [15:0] w;
  logic [1:0] c;
  logic light_enable = 1'h0;
  logic prox_enable = 1'h0;
  logic wait_enable = 1'h0;
  logic [7:0] status_in = 8'ha5;
  logic light_valid = 1'h0;
  logic prox_valid = 1'h0;
  logic [15:0] clear_in = '0;
  logic [15:0] ir_in = '0;
  logic [15:0] prox_in = '0;
  logic led_pulse;
  logic clear_sel;
  logic ir_sel;
  logic light_done;
  logic prox_done;
  logic [9:0] sink;
  logic [6:0] gain;
  logic [9:0] sinks [4] = '{10'h3e8, 10'h1f4, 10'h0fa, 10'h07d};
  logic [6:0] gains [4] = '{7'h01, 7'h08, 7'h10, 7'h78};
  logic [15:0] olds [3] = '{16'h1234, 16'h5678, 16'h9abc};
  logic [15:0] news [3] = '{16'hbeef, 16'hcafe, 16'hf00d};
  int failures = 0;
  int compares = 0;
  int per0;
  int per1;
  int per2;
  int pulses;
  int gap;
  int lights;

  always #50 sys_clk = ~sys_clk;
  always #40 link_clk = ~link_clk;

  light_prox_regs #(.STEP_CYCLES(STEP)) dut_u
  (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .host_req(host_req),
    .host_cmd(host_cmd), .host_busy(host_busy), .host_done(host_done),
    .host_rdata(host_rdata), .light_enable(light_enable), .prox_enable(prox_enable),
    .wait_enable(wait_enable), .integration_time_setting(8'hfe), .wait_time_setting(8'hff),
    .status_in(status_in), .light_result_valid(light_valid), .clear_result_in(clear_in),
    .ir_result_in(ir_in), .prox_result_valid(prox_valid), .prox_result_in(prox_in),
    .led_pulse(led_pulse), .led_sink_tenth_ma(sink), .photodiode_clear_sel(clear_sel),
    .photodiode_ir_sel(ir_sel), .light_gain_factor(gain), .light_cycle_done(light_done),
    .prox_cycle_done(prox_done)
  );

  host_link_model host_u
  (
    .link_clk(link_clk), .rst(rst), .host_req(host_req), .host_cmd(host_cmd),
    .host_busy(host_busy), .host_done(host_done), .host_rdata(host_rdata)
  );

  // ==========================================================
  // Compare and helper tasks
  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task automatic chk_cnt(input string name, input int exp, input int got);
    compares++;
    if (got != exp)
    begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  task automatic load(input int k, input logic [15:0] v);
    @(negedge sys_clk);
    clear_in = k == 0 ? v : 16'h0000;
    ir_in = k == 1 ? v : 16'h0000;
    prox_in = k == 2 ? v : 16'h0000;
    light_valid = 1'h1;
    prox_valid = 1'h1;
    @(negedge sys_clk);
    light_valid = 1'h0;
    prox_valid = 1'h0;
  endtask : load

  // Spans one sequencer round, from one proximity end to the next.
  task automatic measure(output int period, output int npulse, output int pgap,
                         output int nlight);
    int last;
    logic prev;
    period = 0;
    npulse = 0;
    pgap = 0;
    nlight = 0;
    last = 0;
    @(negedge sys_clk);
    while (prox_done !== 1'h1 && period < 20000)
    begin
      @(negedge sys_clk);
      period++;
    end
    period = 0;
    prev = led_pulse;
    do
    begin
      @(negedge sys_clk);
      period++;
      if (led_pulse === 1'h1 && prev !== 1'h1)
      begin
        if (npulse > 0) pgap = period - last;
        last = period;
        npulse++;
      end
      prev = led_pulse;
      if (light_done === 1'h1) nlight++;
    end
    while (prox_done !== 1'h1 && period < 20000);
    if (period >= 20000) failures++;
  endtask : measure

  task automatic stop_test();
    failures += host_u.timeouts;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // Scenarios
  initial
  begin
    #3000000;
    failures++;
    stop_test();
  end

  initial
  begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'h0;
    for (int a = 13; a < 16; a++)
    begin
      host_u.read_reg(8'(a), rd);
      chk_val("setting after reset", 16'h0000, {8'h00, rd});
    end
    host_u.write_reg(8'h0e, 8'h03);
    host_u.read_reg(8'h0e, rd);
    chk_val("pulse count", 16'h0003, {8'h00, rd});
    for (int k = 0; k < 4; k++)
    begin
      c = 2'(k);
      host_u.write_reg(8'h0f, {c, c, 2'h0, c});
      host_u.read_reg(8'h0f, rd);
      chk_val("control", {8'h00, c, c, 2'h0, c}, {8'h00, rd});
      chk_val("sink", {6'h00, sinks[k]}, {6'h00, sink});
      chk_val("gain", {9'h000, gains[k]}, {9'h000, gain});
      chk_val("diode", {14'h0000, c}, {14'h0000, ir_sel, clear_sel});
    end
    host_u.read_reg(8'h12, id0);
    host_u.write_reg(8'h12, ~id0);
    host_u.read_reg(8'h12, rd);
    chk_val("identity", {8'h00, id0}, {8'h00, rd});
    host_u.write_reg(8'h13, 8'h3c);
    host_u.read_reg(8'h13, rd);
    chk_val("status", 16'h00a5, {8'h00, rd});
    host_u.write_reg(8'h1a, 8'hff);
    host_u.read_reg(8'h1a, rd);
    chk_val("unmapped", 16'h0000, {8'h00, rd});
    for (int k = 0; k < 3; k++)
    begin
      load(k, olds[k]);
      host_u.read_reg(8'(20 + 2 * k), rd);
      chk_val("result low", {8'h00, olds[k][7:0]}, {8'h00, rd});
      load(k, news[k]);
      host_u.read_reg(8'(21 + 2 * k), rd);
      chk_val("shadow high", {8'h00, olds[k][15:8]}, {8'h00, rd});
      host_u.read16(8'(20 + 2 * k), w);
      chk_val("result word", news[k], w);
    end
    @(negedge sys_clk);
    light_enable = 1'h1;
    prox_enable = 1'h1;
    wait_enable = 1'h1;
    measure(per0, pulses, gap, lights);
    measure(per0, pulses, gap, lights);
    chk_cnt("pulses", 3, pulses);
    chk_cnt("pulse spacing", 160, gap);
    chk_cnt("light ends", 1, lights);
    host_u.write_reg(8'h0d, 8'h02);
    measure(per1, pulses, gap, lights);
    measure(per1, pulses, gap, lights);
    chk_cnt("long wait", 11 * STEP, per1 - per0);
    @(negedge sys_clk);
    light_enable = 1'h0;
    measure(per2, pulses, gap, lights);
    measure(per2, pulses, gap, lights);
    chk_cnt("round without light", per1, per2);
    chk_cnt("light ends", 1, lights);
    stop_test();
  end
endmodule : light_prox_regs_tb
`default_nettype wire
